// File: hw/sstg_map.svh
`ifndef SSTG_MAP_SVH
`define SSTG_MAP_SVH
// Notes on behaviour
// - All timing comes from one master reference at 31,500 per second, twice line rate.
// - Main chain divides the reference by 525 in stages of 7, 5, 5, 3.
// - A divide-by-N stage stays active over N-1 but under N periods, restarts on Nth.
// - Triggers during the active interval are ignored; one output trigger per cycle.
// - Field-rate trigger starts vertical blanking, width set by the vertical blanking timer.
// - Vertical drive starts with vertical blanking and is shorter than it if blanking is two lines or more.
// - A divide-by-two of the master reference gives the 15,750 line rate.
// - Horizontal blanking and drive built like vertical; drive narrower if blanking is two cycles or more.
// - Composite blanking merges both blankings; vertical blanking covers the horizontal pulses.
// - Sync widths are 2.38 us equalizing, 4.76 us horizontal, 27.3 us vertical.
// - Outside the vertical interval only 4.76 us horizontal sync at line rate.
// - Nine lines per field carry sync at twice line rate, in three groups of six.
// - Sync fires only in horizontal blanking, except on every trigger in the interval.
// - The nine-line interval splits into three three-line parts, narrow or wide pulses.
// - Equalizing and vertical sync gates come from chained timers started by field trigger.
// - Gate timers count a divide-by-three of the reference, edges on reference ticks.
// - Active equalizing or vertical gate selects the narrow or wide sync width.
// - Line blanking and the front porch delay start on one edge; porch end fires sync.
// - Front porch delay is adjustable and keeps its value once loaded.
// - Reference free-runs at nominal rate and takes a frequency-correction input.
// - Four frequency-reference modes are chosen by a selector.
// - Power-line mode steers the reference to hold field phase against the mains.
// - Crystal mode divides a 94,500 per second crystal by three.
// - External mode takes the reference from an external subcarrier-derived standard.
// - Remote mode injects extra counts until local and remote vertical coincide.

`define SSTG_CLK_HZ      100000000
`define SSTG_CLK_NS      10
`define SSTG_REF_HZ      31500
`define SSTG_NCO_STEP    (64'h0000_0000_0000_7b0c * 64'h0000_0001_0000_0000 / 64'h0000_0000_05f5_e100)
`define SSTG_XTAL_DIV    3
`define SSTG_MAIN_N1     7
`define SSTG_MAIN_N2     5
`define SSTG_MAIN_N3     5
`define SSTG_MAIN_N4     3
`define SSTG_LINE_N      2
`define SSTG_VI_N        3
`define SSTG_VI_TRI      2
`define SSTG_EQ_NS       2380
`define SSTG_HS_NS       4760
`define SSTG_VS_NS       27300
`define SSTG_PORCH_NS    1500
`define SSTG_HBL_NS      11100
`define SSTG_HDRV_NS     6300
`define SSTG_EQ_CYC      (`SSTG_EQ_NS / `SSTG_CLK_NS)
`define SSTG_HS_CYC      (`SSTG_HS_NS / `SSTG_CLK_NS)
`define SSTG_VS_CYC      (`SSTG_VS_NS / `SSTG_CLK_NS)
`define SSTG_PORCH_CYC   (`SSTG_PORCH_NS / `SSTG_CLK_NS)
`define SSTG_HBL_CYC     (`SSTG_HBL_NS / `SSTG_CLK_NS)
`define SSTG_HDRV_CYC    (`SSTG_HDRV_NS / `SSTG_CLK_NS)
`define SSTG_VBL_LINES   20
`define SSTG_VDRV_LINES  9
`define SSTG_CORR_LIM    16'h0800
`define SSTG_LOCK_PHASE  22'h00_0000
`define SSTG_MAINS_MAX   22'h3f_ffff

`endif

// File: hw/sstg_pkg.sv
package sstg_pkg;

   typedef enum logic [1:0] {
      SSTG_LINE_LOCK = 2'b00,
      SSTG_CRYSTAL   = 2'b01,
      SSTG_EXTERNAL  = 2'b10,
      SSTG_REMOTE    = 2'b11
   } sstg_mode_type;

   typedef enum logic [1:0] {
      SSTG_VI_IDLE = 2'b00,
      SSTG_VI_PRE  = 2'b01,
      SSTG_VI_VS   = 2'b10,
      SSTG_VI_POST = 2'b11
   } sstg_vi_type;

   typedef logic [15:0] sstg_width_type;

endpackage : sstg_pkg

// File: hw/sstg_stage_if.sv
`timescale 1ns/1ps
interface sstg_stage_if;
   logic trig_in;
   logic active;
   logic trig_out;
   modport stage (input trig_in, output active, output trig_out);
   modport feed  (output trig_in, input active, input trig_out);
endinterface : sstg_stage_if

// File: hw/sstg_div_stage.sv
`timescale 1ns/1ps
module sstg_div_stage #(
   parameter int unsigned N = 5
) (
   // Clock and reset
   input  logic               core_clk,
   input  logic               resetn,
   // Trigger path
   sstg_stage_if.stage        ifc
);
   localparam int unsigned CW = (N > 2) ? $clog2(N) : 1;

   typedef struct packed {
      logic          active;
      logic          tail;
      logic          out;
      logic [CW-1:0] cnt;
   } sstg_div_st_type;

   sstg_div_st_type st_ff;
   sstg_div_st_type nxt_st;

   always_comb begin
      nxt_st     = st_ff;
      nxt_st.out = 1'b0;
      // Tail keeps the interval just past N-1 periods, well short of N
      if (st_ff.tail) begin
         nxt_st.active = 1'b0;
         nxt_st.tail   = 1'b0;
      end else if (ifc.trig_in) begin
         if (!st_ff.active) begin
            nxt_st.active = 1'b1;
            nxt_st.cnt    = '0;
            nxt_st.out    = 1'b1;
         end else if (st_ff.cnt == CW'(N - 2)) begin
            nxt_st.tail = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign ifc.active   = st_ff.active;
   assign ifc.trig_out = st_ff.out;
endmodule : sstg_div_stage

// File: hw/sstg_pulse_timer.sv
`timescale 1ns/1ps
module sstg_pulse_timer (
   // Clock and reset
   input  logic                    core_clk,
   input  logic                    resetn,
   // Control
   input  logic                    start,
   input  sstg_pkg::sstg_width_type width,
   // Status
   output logic                    active,
   output logic                    done
);
   typedef struct packed {
      logic                     active;
      logic                     done;
      sstg_pkg::sstg_width_type cnt;
   } sstg_pt_st_type;

   sstg_pt_st_type st_ff;
   sstg_pt_st_type nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      // Monostable: a start while running is ignored
      if (st_ff.active) begin
         if (st_ff.cnt <= 16'h0001) begin
            nxt_st.active = 1'b0;
            nxt_st.done   = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt - 16'h0001;
         end
      end else if (start) begin
         nxt_st.active = 1'b1;
         nxt_st.cnt    = (width == 16'h0000) ? 16'h0001 : width;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign active = st_ff.active;
   assign done   = st_ff.done;
endmodule : sstg_pulse_timer

// File: hw/sstg_timing_gen.sv
`timescale 1ns/1ps
`include "sstg_map.svh"
module sstg_timing_gen #(
   parameter logic [15:0] HBL_CYC    = 16'(`SSTG_HBL_CYC),
   parameter logic [15:0] HDRV_CYC   = 16'(`SSTG_HDRV_CYC),
   parameter logic [9:0]  VBL_LINES  = 10'(`SSTG_VBL_LINES),
   parameter logic [9:0]  VDRV_LINES = 10'(`SSTG_VDRV_LINES),
   parameter logic [21:0] LOCK_PHASE = `SSTG_LOCK_PHASE,
   parameter logic [15:0] CORR_LIM   = `SSTG_CORR_LIM
) (
   // Clock and reset
   input  logic                     core_clk,
   input  logic                     resetn,
   // Frequency reference
   input  sstg_pkg::sstg_mode_type  mode_sel,
   input  logic signed [15:0]       freq_corr,
   input  logic                     xtal_tick,
   input  logic                     ext_ref_tick,
   input  logic                     mains_tick,
   input  logic                     remote_vsync,
   // Front porch setting
   input  sstg_pkg::sstg_width_type porch_set,
   input  logic                     porch_load,
   // Timing outputs
   output logic                     hblank,
   output logic                     hdrive,
   output logic                     vblank,
   output logic                     vdrive,
   output logic                     comp_blank,
   output logic                     comp_sync,
   output logic                     eq_gate,
   output logic                     vs_gate,
   output logic                     field_pulse,
   output logic                     misaligned
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [31:0]           acc;
      logic signed [15:0]    loop_corr;
      logic [21:0]           mains_cnt;
      logic [1:0]            xdiv;
      logic                  tick_d;
      sstg_pkg::sstg_vi_type vi;
      logic [1:0]            ph3;
      logic                  tri_n;
      logic [9:0]            vcnt;
      logic                  vbl;
      logic                  vdrv;
      logic [15:0]           porch;
      logic                  misalign;
      logic                  rem_win;
      logic                  loc_win;
      logic                  o_hbl;
      logic                  o_hdrv;
      logic                  o_vbl;
      logic                  o_vdrv;
      logic                  o_cbl;
      logic                  o_csync;
      logic                  o_eq;
      logic                  o_vs;
      logic                  o_field;
   } sstg_core_st_type;

   sstg_core_st_type st_ff;
   sstg_core_st_type nxt_st;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Drive stays below blanking for any blanking width of two or more
   function automatic logic [15:0] narrower(input logic [15:0] drv,
                                           input logic [15:0] blk);
      logic [15:0] res;
      res = (drv < blk) ? drv : (blk - 16'h0001);
      if (res == 16'h0000) begin
         res = 16'h0001;
      end
      return res;
   endfunction : narrower

   localparam logic [15:0] HDRV_EFF = narrower(HDRV_CYC, HBL_CYC);
   localparam logic [9:0]  VDRV_EFF = 10'(narrower({6'h00, VDRV_LINES},
                                                   {6'h00, VBL_LINES}));
   localparam logic [31:0] NCO_STEP = 32'(`SSTG_NCO_STEP);

   ////////////////////////////////////////////////////////////////////////////////
   // Master reference

   logic               ref_tick;
   logic               half_tick;
   logic               nco_tick;
   logic signed [15:0] corr;
   logic [31:0]        step;
   logic [32:0]        nco_sum;
   logic               inject;
   logic               field_trig;
   logic               line_trig;

   always_comb begin
      corr = (mode_sel == sstg_pkg::SSTG_LINE_LOCK) ? st_ff.loop_corr : freq_corr;
      step = NCO_STEP + {{16{corr[15]}}, corr};
      nco_sum   = {1'b0, st_ff.acc} + {1'b0, step};
      nco_tick  = nco_sum[32];
      half_tick = !st_ff.acc[31] && nco_sum[31] && !nco_sum[32];
      unique case (mode_sel)
         sstg_pkg::SSTG_CRYSTAL:
            ref_tick = xtal_tick && (st_ff.xdiv == 2'(`SSTG_XTAL_DIV - 1));
         sstg_pkg::SSTG_EXTERNAL:
            ref_tick = ext_ref_tick;
         sstg_pkg::SSTG_LINE_LOCK,
         sstg_pkg::SSTG_REMOTE:
            ref_tick = nco_tick;
      endcase
      // Extra count lands mid-period so it never merges with a real tick
      inject = (mode_sel == sstg_pkg::SSTG_REMOTE) && st_ff.misalign && half_tick;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Divider chains

   sstg_stage_if st7_if ();
   sstg_stage_if st5a_if ();
   sstg_stage_if st5b_if ();
   sstg_stage_if st3_if ();
   sstg_stage_if st2_if ();

   assign st7_if.trig_in  = st_ff.tick_d | inject;
   assign st5a_if.trig_in = st7_if.trig_out;
   assign st5b_if.trig_in = st5a_if.trig_out;
   assign st3_if.trig_in  = st5b_if.trig_out;
   assign st2_if.trig_in  = ref_tick;
   assign field_trig      = st3_if.trig_out;
   assign line_trig       = st2_if.trig_out;

   sstg_div_stage #(.N(`SSTG_MAIN_N1)) u_div7 (
      .core_clk (core_clk),
      .resetn   (resetn),
      .ifc      (st7_if.stage)
   );

   sstg_div_stage #(.N(`SSTG_MAIN_N2)) u_div5a (
      .core_clk (core_clk),
      .resetn   (resetn),
      .ifc      (st5a_if.stage)
   );

   sstg_div_stage #(.N(`SSTG_MAIN_N3)) u_div5b (
      .core_clk (core_clk),
      .resetn   (resetn),
      .ifc      (st5b_if.stage)
   );

   sstg_div_stage #(.N(`SSTG_MAIN_N4)) u_div3 (
      .core_clk (core_clk),
      .resetn   (resetn),
      .ifc      (st3_if.stage)
   );

   sstg_div_stage #(.N(`SSTG_LINE_N)) u_div2 (
      .core_clk (core_clk),
      .resetn   (resetn),
      .ifc      (st2_if.stage)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Horizontal pulses, porch and sync

   logic                     hbl_act;
   logic                     hdrv_act;
   logic                     porch_done;
   logic                     sync_start;
   logic                     sync_act;
   sstg_pkg::sstg_width_type sync_w;

   sstg_pulse_timer u_hblank (
      .core_clk (core_clk),
      .resetn   (resetn),
      .start    (line_trig),
      .width    (HBL_CYC),
      .active   (hbl_act),
      .done     ()
   );

   sstg_pulse_timer u_hdrive (
      .core_clk (core_clk),
      .resetn   (resetn),
      .start    (line_trig),
      .width    (HDRV_EFF),
      .active   (hdrv_act),
      .done     ()
   );

   // Porch starts with the same delayed edge that starts line blanking
   sstg_pulse_timer u_porch (
      .core_clk (core_clk),
      .resetn   (resetn),
      .start    (st_ff.tick_d),
      .width    (st_ff.porch),
      .active   (),
      .done     (porch_done)
   );

   always_comb begin
      unique case (st_ff.vi)
         sstg_pkg::SSTG_VI_PRE,
         sstg_pkg::SSTG_VI_POST: sync_w = 16'(`SSTG_EQ_CYC);
         sstg_pkg::SSTG_VI_VS:   sync_w = 16'(`SSTG_VS_CYC);
         sstg_pkg::SSTG_VI_IDLE: sync_w = 16'(`SSTG_HS_CYC);
      endcase
      // Mid-line ticks fall outside blanking and are dropped, except in the nine-line interval
      sync_start = porch_done && (hbl_act || (st_ff.vi != sstg_pkg::SSTG_VI_IDLE));
   end

   sstg_pulse_timer u_sync (
      .core_clk (core_clk),
      .resetn   (resetn),
      .start    (sync_start),
      .width    (sync_w),
      .active   (sync_act),
      .done     ()
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   logic coincide;

   always_comb begin
      nxt_st        = st_ff;
      nxt_st.acc    = nco_sum[31:0];
      nxt_st.tick_d = ref_tick;

      if (xtal_tick) begin
         nxt_st.xdiv = (st_ff.xdiv == 2'(`SSTG_XTAL_DIV - 1)) ? 2'h0
                                                             : st_ff.xdiv + 2'h1;
      end

      // Power-line phase loop: one step per field, clamped
      if (mains_tick) begin
         nxt_st.mains_cnt = 22'h00_0000;
      end else if (st_ff.mains_cnt != `SSTG_MAINS_MAX) begin
         nxt_st.mains_cnt = st_ff.mains_cnt + 22'h00_0001;
      end
      if (field_trig && (mode_sel == sstg_pkg::SSTG_LINE_LOCK)) begin
         if (st_ff.mains_cnt > LOCK_PHASE) begin
            if (st_ff.loop_corr < signed'(CORR_LIM)) begin
               nxt_st.loop_corr = st_ff.loop_corr + 16'sh0001;
            end
         end else if (st_ff.loop_corr > -signed'(CORR_LIM)) begin
            nxt_st.loop_corr = st_ff.loop_corr - 16'sh0001;
         end
      end

      // Remote vertical alignment
      coincide = (field_trig && (st_ff.rem_win || remote_vsync)) ||
                 (remote_vsync && st_ff.loc_win);
      if (ref_tick) begin
         nxt_st.rem_win = 1'b0;
         nxt_st.loc_win = 1'b0;
      end
      if (remote_vsync) begin
         nxt_st.rem_win = 1'b1;
      end
      if (field_trig) begin
         nxt_st.loc_win = 1'b1;
      end
      if (mode_sel != sstg_pkg::SSTG_REMOTE) begin
         nxt_st.misalign = 1'b0;
      end else if (coincide) begin
         nxt_st.misalign = 1'b0;
      end else if (remote_vsync) begin
         nxt_st.misalign = 1'b1;
      end

      // Vertical blanking and drive in lines
      if (field_trig) begin
         nxt_st.vbl  = 1'b1;
         nxt_st.vdrv = 1'b1;
         nxt_st.vcnt = 10'h000;
      end else if (line_trig && st_ff.vbl) begin
         nxt_st.vcnt = st_ff.vcnt + 10'h001;
         if (st_ff.vcnt + 10'h001 >= VDRV_EFF) begin
            nxt_st.vdrv = 1'b0;
         end
         if (st_ff.vcnt + 10'h001 >= VBL_LINES) begin
            nxt_st.vbl = 1'b0;
         end
      end

      // Nine-line interval: six reference ticks per three-line part
      if (field_trig) begin
         nxt_st.vi    = sstg_pkg::SSTG_VI_PRE;
         nxt_st.ph3   = 2'h0;
         nxt_st.tri_n = 1'b0;
      end else if (ref_tick && (st_ff.vi != sstg_pkg::SSTG_VI_IDLE)) begin
         if (st_ff.ph3 == 2'(`SSTG_VI_N - 1)) begin
            nxt_st.ph3 = 2'h0;
            if (st_ff.tri_n == 1'(`SSTG_VI_TRI - 1)) begin
               nxt_st.tri_n = 1'b0;
               unique case (st_ff.vi)
                  sstg_pkg::SSTG_VI_PRE:  nxt_st.vi = sstg_pkg::SSTG_VI_VS;
                  sstg_pkg::SSTG_VI_VS:   nxt_st.vi = sstg_pkg::SSTG_VI_POST;
                  sstg_pkg::SSTG_VI_POST: nxt_st.vi = sstg_pkg::SSTG_VI_IDLE;
                  sstg_pkg::SSTG_VI_IDLE: nxt_st.vi = sstg_pkg::SSTG_VI_IDLE;
               endcase
            end else begin
               nxt_st.tri_n = st_ff.tri_n + 1'b1;
            end
         end else begin
            nxt_st.ph3 = st_ff.ph3 + 2'h1;
         end
      end

      // Porch value holds until the next load
      if (porch_load) begin
         nxt_st.porch = (porch_set == 16'h0000) ? 16'h0001 : porch_set;
      end

      // Registered outputs
      nxt_st.o_hbl   = hbl_act;
      nxt_st.o_hdrv  = hdrv_act;
      nxt_st.o_vbl   = st_ff.vbl;
      nxt_st.o_vdrv  = st_ff.vdrv;
      nxt_st.o_cbl   = hbl_act || st_ff.vbl;
      nxt_st.o_csync = sync_act;
      nxt_st.o_eq    = (st_ff.vi == sstg_pkg::SSTG_VI_PRE) ||
                       (st_ff.vi == sstg_pkg::SSTG_VI_POST);
      nxt_st.o_vs    = (st_ff.vi == sstg_pkg::SSTG_VI_VS);
      nxt_st.o_field = field_trig;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st_ff       <= '0;
         st_ff.porch <= 16'(`SSTG_PORCH_CYC);
         st_ff.vi    <= sstg_pkg::SSTG_VI_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign hblank      = st_ff.o_hbl;
   assign hdrive      = st_ff.o_hdrv;
   assign vblank      = st_ff.o_vbl;
   assign vdrive      = st_ff.o_vdrv;
   assign comp_blank  = st_ff.o_cbl;
   assign comp_sync   = st_ff.o_csync;
   assign eq_gate     = st_ff.o_eq;
   assign vs_gate     = st_ff.o_vs;
   assign field_pulse = st_ff.o_field;
   assign misaligned  = st_ff.misalign;

endmodule : sstg_timing_gen

// File: tb/sstg_ref_partner.sv
`timescale 1ns/1ps
module sstg_ref_partner (
   // Clock and reset
   input  logic        core_clk,
   input  logic        resetn,
   // Spacing of reference ticks in clock cycles
   input  logic [15:0] period,
   // Reference out
   output logic        ext_ref_tick,
   output logic [15:0] n_tick
);
   logic [15:0] cnt_ff;
   // Greater-or-equal so a shortened period takes effect at once
   always @(posedge core_clk) begin
      ext_ref_tick <= 1'b0;
      if (!resetn) begin
         cnt_ff <= 16'h0000;
         n_tick <= 16'h0000;
      end else if (cnt_ff >= period - 16'h0001) begin
         cnt_ff <= 16'h0000;
         ext_ref_tick <= 1'b1;
         n_tick <= n_tick + 16'h0001;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end
endmodule : sstg_ref_partner

// File: tb/sstg_timing_gen_asserts.sv
`timescale 1ns/1ps
`include "sstg_map.svh"
module sstg_timing_gen_asserts (
   // Clock and reset
   input logic core_clk,
   input logic resetn,
   // Timing outputs
   input logic hblank,
   input logic hdrive,
   input logic vblank,
   input logic vdrive,
   input logic comp_blank,
   input logic comp_sync,
   input logic eq_gate,
   input logic vs_gate,
   input logic field_pulse
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // Held through the falling edge so the width is seen there
   logic [15:0] sync_len_ff;
   always_ff @(posedge core_clk) begin
      if (!resetn || !comp_sync) begin
         sync_len_ff <= 16'h0000;
      end else begin
         sync_len_ff <= sync_len_ff + 16'h0001;
      end
   end
   sync_width_a: assert property ($fell(comp_sync) |-> sync_len_ff inside
      {16'(`SSTG_EQ_CYC), 16'(`SSTG_HS_CYC), 16'(`SSTG_VS_CYC)}) else $error("sync width");
   sync_gate_a: assert property ($rose(comp_sync) |-> comp_blank || eq_gate || vs_gate)
      else $error("sync outside blanking");
   blank_merge_a: assert property (vblank [*2] |-> comp_blank)
      else $error("composite blank gap");
   hdrive_short_a: assert property ($fell(hblank) |-> !$past(hdrive))
      else $error("line drive too wide");
   vdrive_short_a: assert property ($fell(vblank) |-> !$past(vdrive))
      else $error("field drive too wide");
   field_blank_a: assert property (field_pulse |-> ##1 $rose(vblank))
      else $error("field blank late");
   field_single_a: assert property (field_pulse |=> !field_pulse)
      else $error("field pulse too long");
   gate_order_a: assert property ($rose(vs_gate) |-> !eq_gate && $past(eq_gate, 2))
      else $error("gate order");
endmodule : sstg_timing_gen_asserts
////////////////////////////////////////////////////////////
bind sstg_timing_gen sstg_timing_gen_asserts u_chk (.core_clk(core_clk), .resetn(resetn),
   .hblank(hblank), .hdrive(hdrive), .vblank(vblank), .vdrive(vdrive),
   .comp_blank(comp_blank), .comp_sync(comp_sync), .eq_gate(eq_gate), .vs_gate(vs_gate),
   .field_pulse(field_pulse));

// File: tb/tb_studio_sync_timing_generator.sv
`timescale 1ns/1ps
`include "sstg_map.svh"
`define CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("ERROR %0t: got %0h expected %0h", $time, (got), (exp)); \
      end \
   end
module tb_studio_sync_timing_generator;
   logic                     core_clk, resetn, porch_load, ext_ref_tick;
   sstg_pkg::sstg_width_type porch_set;
   sstg_pkg::sstg_mode_type  mode;
   logic [15:0]              period, n_tick, n0;
   logic                     hblank, hdrive, vblank, vdrive, comp_blank, comp_sync;
   logic                     eq_gate, vs_gate, field_pulse, misaligned;
   int                       checks = 0;
   int                       n_mismatch = 0;
   int                       cyc = 0;
   sstg_timing_gen #(.HBL_CYC(16'h0064), .HDRV_CYC(16'h003c)) dut (
      .core_clk(core_clk), .resetn(resetn), .mode_sel(mode),
      .freq_corr(16'h0000), .xtal_tick(ext_ref_tick), .ext_ref_tick(ext_ref_tick),
      .mains_tick(1'b0), .remote_vsync(1'b0), .porch_set(porch_set), .porch_load(porch_load),
      .hblank(hblank), .hdrive(hdrive), .vblank(vblank), .vdrive(vdrive),
      .comp_blank(comp_blank), .comp_sync(comp_sync), .eq_gate(eq_gate), .vs_gate(vs_gate),
      .field_pulse(field_pulse), .misaligned(misaligned));
   sstg_ref_partner u_ref (.core_clk(core_clk), .resetn(resetn), .period(period),
      .ext_ref_tick(ext_ref_tick), .n_tick(n_tick));
   ////////////////////////////////////////////////////////////
   task automatic to_tick(input logic [15:0] t);
      while (n_tick !== t) @(negedge core_clk);
   endtask : to_tick
   task automatic gate_at(input logic [15:0] t, input logic eq, input logic vs);
      to_tick(t);
      repeat (300) @(negedge core_clk);
      `CHK(eq_gate, eq)
      `CHK(vs_gate, vs)
   endtask : gate_at
   task automatic test_interval;
      int   rises = 0;
      int   high = 0;
      logic prev = 1'b0;
      while (field_pulse !== 1'b1) @(negedge core_clk);
      n0 = n_tick;
      while (n_tick !== 16'(n0 + 16'h0006)) begin
         if (comp_sync === 1'b1 && prev !== 1'b1) rises++;
         high += int'(comp_sync === 1'b1);
         prev = comp_sync;
         @(negedge core_clk);
      end
      `CHK(rises, 6)
      `CHK(high, 6 * `SSTG_EQ_CYC)
      gate_at(16'(n0 + 16'h0009), 1'b0, 1'b1);
      gate_at(16'(n0 + 16'h000f), 1'b1, 1'b0);
      gate_at(16'(n0 + 16'h0014), 1'b0, 1'b0);
      $display("test interval done");
   endtask : test_interval
   task automatic test_field;
      logic [15:0] n1;
      period = 16'h0064;
      repeat (2) @(negedge core_clk);
      while (field_pulse !== 1'b1) @(negedge core_clk);
      n1 = n_tick;
      `CHK(16'(n1 - n0), 16'h020d)
      repeat (3) @(negedge core_clk);
      `CHK(vblank, 1'b1)
      // Mid-line tick: line blanking is low here, so only vertical holds it
      `CHK(comp_blank, 1'b1)
      to_tick(16'(n1 + 16'h0014));
      `CHK(vdrive, 1'b0)
      to_tick(16'(n1 + 16'h0026));
      `CHK(vblank, 1'b1)
      to_tick(16'(n1 + 16'h002a));
      `CHK(vblank, 1'b0)
      $display("test field done");
   endtask : test_field
   task automatic test_line;
      int   hb = 0;
      int   hd = 0;
      int   sy = 0;
      int   n_sy = 0;
      int   t_sy = 0;
      logic prev = 1'b0;
      period = 16'h0bb8;
      while (hblank !== 1'b0) @(negedge core_clk);
      while (hblank !== 1'b1) @(negedge core_clk);
      // Window spans the mid-line tick but stops short of the next line
      for (int i = 0; i < 5900; i++) begin
         hb += int'(hblank === 1'b1);
         hd += int'(hdrive === 1'b1);
         sy += int'(comp_sync === 1'b1);
         if (comp_sync === 1'b1 && prev !== 1'b1) begin
            n_sy++;
            t_sy = i;
         end
         prev = comp_sync;
         @(negedge core_clk);
      end
      `CHK(hb, 100)
      `CHK(hd, 60)
      `CHK(sy, `SSTG_HS_CYC)
      `CHK(n_sy, 1)
      `CHK(t_sy, 21)
      `CHK(misaligned, 1'b0)
      $display("test line done");
   endtask : test_line
   task automatic test_crystal;
      logic [15:0] n2;
      mode = sstg_pkg::SSTG_CRYSTAL;
      period = 16'h00c8;
      // Skip the line started around the mode switch
      repeat (2) begin
         while (hblank !== 1'b0) @(negedge core_clk);
         while (hblank !== 1'b1) @(negedge core_clk);
      end
      n2 = n_tick;
      while (hblank !== 1'b0) @(negedge core_clk);
      while (hblank !== 1'b1) @(negedge core_clk);
      `CHK(16'(n_tick - n2), 16'h0006)
      $display("test crystal done");
   endtask : test_crystal
   task final_report;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 100000) begin
         n_mismatch++;
         final_report;
      end
   end
   initial begin
      resetn = 1'b0;
      porch_set = 16'h0014;
      porch_load = 1'b0;
      period = 16'h0258;
      mode = sstg_pkg::SSTG_EXTERNAL;
      repeat (3) @(negedge core_clk);
      resetn = 1'b1;
      porch_load = 1'b1;
      @(negedge core_clk);
      porch_load = 1'b0;
      test_interval;
      test_field;
      test_line;
      test_crystal;
      final_report;
   end
endmodule : tb_studio_sync_timing_generator
